/* File: design/cwr_config_word_retry_write.sv */
// Purpose: Command interpreter driving the read/write head
// Assumes: Head and tag inputs synchronous to ref_clk
// Notes: Avalon-MM slave, one wait state per access
//
// Local design decisions: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
module cwr_config_word_retry_write (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    output logic head_req,
    output logic [1:0] head_op,
    output logic [7:0] head_addr,
    output logic [31:0] head_data,
    output logic [3:0] head_len,
    output logic head_verify,
    input wire logic head_done,
    input wire logic head_ok,
    input wire logic [7:0] head_status,
    input wire logic [31:0] head_rdata,
    input wire logic tag_present,
    input wire logic tag_new
);
    // ****************************************
    // Reset release
    // ****************************************
    logic [1:0] rst_sync_reg;
    wire logic rst_n = rst_sync_reg[1];
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            rst_sync_reg <= 2'b00;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end

    // ****************************************
    // Bus slave
    // ****************************************
    logic served_reg;
    wire logic access = avs_read | avs_write;
    wire logic wr_acc = avs_write & served_reg;
    assign avs_waitrequest = access & ~served_reg;
    logic [31:0] cmd_reg [3];
    logic [31:0] ctrl_reg, irq_st_reg, irq_en_reg, code_reg, rd_next;
    logic [7:0] rsp_ctrl_reg, rsp_cmd_reg, rsp_status_reg, rsp_count_reg;
    cwr_pkg::cwr_state_t state_reg, state_next;
    wire logic cmd_start = wr_acc && avs_address == cwr_pkg::OFS_CMD0;
    wire logic clr_acc = wr_acc && avs_address == cwr_pkg::OFS_IRQ_CLR;
    wire logic [7:0] cmd_code = cmd_reg[0][23:16];
    wire logic [7:0] cfg_addr = cmd_reg[1][15:8];
    // Data byte 8 lands as most significant
    wire logic [31:0] cmd_data = {cmd_reg[2][7:0], cmd_reg[2][15:8],
        cmd_reg[2][23:16], cmd_reg[2][31:24]};
    wire logic pw_mode = ctrl_reg[cwr_pkg::CTRL_PW_BIT];
    wire logic [1:0] tag_type = ctrl_reg[cwr_pkg::CTRL_TT_LSB +: 2];
    wire logic is_cfg = cmd_code == cwr_pkg::CMD_CFG_RETRY;
    wire logic is_fwr = cmd_code == cwr_pkg::CMD_FIX_WR_S || cmd_code == cwr_pkg::CMD_FIX_WR_E;
    wire logic is_frd = cmd_code == cwr_pkg::CMD_FIX_RD_S || cmd_code == cwr_pkg::CMD_FIX_RD_E;

    always_comb
    begin
        rd_next = 32'h0000_0000;
        unique case (avs_address)
            cwr_pkg::OFS_CMD0: rd_next = cmd_reg[0];
            cwr_pkg::OFS_CMD1: rd_next = cmd_reg[1];
            cwr_pkg::OFS_CMD2: rd_next = cmd_reg[2];
            // status byte 4, counter byte 5, bytes 6-7 zero
            cwr_pkg::OFS_RSP0: rd_next = {8'h00, rsp_cmd_reg, 8'h00, rsp_ctrl_reg};
            cwr_pkg::OFS_RSP1: rd_next = {16'h0000, rsp_count_reg, rsp_status_reg};
            cwr_pkg::OFS_CTRL: rd_next = ctrl_reg;
            cwr_pkg::OFS_STATE: rd_next = {29'h0, state_reg};
            cwr_pkg::OFS_IRQ_ST: rd_next = irq_st_reg;
            cwr_pkg::OFS_IRQ_EN: rd_next = irq_en_reg;
            cwr_pkg::OFS_CODE: rd_next = code_reg;
            default: rd_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            served_reg <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end
        else
        begin
            served_reg <= access & ~served_reg;
            if (avs_read && !served_reg)
                avs_readdata <= rd_next;
        end
    end

    // Byte-enabled writable registers
    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
        input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (be[i])
                r[8*i +: 8] = wd[8*i +: 8];
        return r;
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_cmd
            always_ff @(posedge ref_clk or negedge rst_n)
            begin
                if (!rst_n)
                    cmd_reg[gi] <= 32'h0000_0000;
                else if (wr_acc && avs_address == 6'(4 * gi))
                    cmd_reg[gi] <= be_merge(cmd_reg[gi], avs_writedata, avs_byteenable);
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_reg <= cwr_pkg::CTRL_RESET;
            irq_en_reg <= 32'h0000_0000;
        end
        else if (wr_acc && avs_address == cwr_pkg::OFS_CTRL)
            ctrl_reg <= be_merge(ctrl_reg, avs_writedata, avs_byteenable);
        else if (wr_acc && avs_address == cwr_pkg::OFS_IRQ_EN)
            irq_en_reg <= be_merge(irq_en_reg, avs_writedata, avs_byteenable);
    end

    // ****************************************
    // Command sequencer
    // ****************************************
    logic resp_evt;
    logic [7:0] resp_status_next;
    logic issue_go;
    always_comb
    begin
        state_next = state_reg;
        resp_evt = 1'b0;
        resp_status_next = cwr_pkg::STAT_OK;
        issue_go = 1'b0;
        unique case (state_reg)
            cwr_pkg::ST_IDLE: state_next = cwr_pkg::ST_IDLE;
            cwr_pkg::ST_START:
            begin
                resp_evt = 1'b1;
                state_next = cwr_pkg::ST_IDLE;
                // no configuration write without password mode
                if (is_cfg && !pw_mode)
                    resp_status_next = cwr_pkg::STAT_NO_PW;
                else if (!is_cfg && !is_fwr && !is_frd)
                    resp_status_next = cwr_pkg::STAT_BAD_CMD;
                // nothing present at execution gives 05h
                else if (!tag_present)
                begin
                    resp_status_next = cwr_pkg::STAT_NO_TAG;
                    if (is_cfg)
                        state_next = cwr_pkg::ST_WAIT_TAG;
                end
                else
                begin
                    resp_evt = 1'b0;
                    state_next = cwr_pkg::ST_ISSUE;
                end
            end
            cwr_pkg::ST_ISSUE:
            begin
                issue_go = 1'b1;
                state_next = cwr_pkg::ST_WAIT_HEAD;
            end
            cwr_pkg::ST_WAIT_HEAD:
                if (head_done)
                begin
                    resp_evt = 1'b1;
                    resp_status_next = head_ok ? cwr_pkg::STAT_OK : head_status;
                    // failed configuration write keeps the command alive
                    state_next = (is_cfg && !head_ok) ? cwr_pkg::ST_WAIT_LEAVE : cwr_pkg::ST_IDLE;
                end
            cwr_pkg::ST_WAIT_LEAVE:
                if (tag_new)
                    state_next = cwr_pkg::ST_START;
                else if (!tag_present)
                begin
                    resp_evt = 1'b1;
                    resp_status_next = cwr_pkg::STAT_NO_TAG;
                    state_next = cwr_pkg::ST_WAIT_TAG;
                end
            cwr_pkg::ST_WAIT_TAG:
                // new tag restarts from the first step
                if (tag_new || tag_present)
                    state_next = cwr_pkg::ST_START;
            default: state_next = cwr_pkg::ST_IDLE;
        endcase
        if (cmd_start)
        begin
            state_next = cwr_pkg::ST_START;
            resp_evt = 1'b0;
            issue_go = 1'b0;
        end
    end

    // Head operation select
    wire logic [1:0] op_next = is_cfg ? cwr_pkg::OP_CFG_WR : is_fwr ? cwr_pkg::OP_FIX_WR :
        (tag_type == cwr_pkg::TT_B_PROG) ? cwr_pkg::OP_RD_NATIVE : cwr_pkg::OP_RD_EMUL;
    wire logic [3:0] len_next = (is_fwr && tag_type == cwr_pkg::TT_B_PROG) ?
        cwr_pkg::LEN_EMUL_AREA : cwr_pkg::LEN_WORD;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= cwr_pkg::ST_IDLE;
            head_req <= 1'b0;
            head_op <= cwr_pkg::OP_CFG_WR;
            head_addr <= 8'h00;
            head_data <= 32'h0000_0000;
            head_len <= cwr_pkg::LEN_WORD;
            head_verify <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            head_req <= issue_go;
            if (issue_go)
            begin
                // programming type reads native code; else emulated
                head_op <= op_next;
                head_addr <= cfg_addr;
                head_data <= cmd_data;
                head_len <= len_next;
                head_verify <= is_cfg & ctrl_reg[cwr_pkg::CTRL_VERIFY_BIT];
            end
        end
    end

    // ****************************************
    // Response frame and interrupts
    // ****************************************
    logic [2:0] evt;
    assign evt = {resp_evt && resp_status_next == cwr_pkg::STAT_NO_TAG,
        resp_evt && resp_status_next == cwr_pkg::STAT_OK && is_cfg, resp_evt};
    assign irq = |(irq_st_reg & irq_en_reg);
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rsp_ctrl_reg <= 8'h00;
            rsp_cmd_reg <= 8'h00;
            rsp_status_reg <= 8'h00;
            rsp_count_reg <= 8'h00;
            code_reg <= 32'h0000_0000;
            irq_st_reg <= 32'h0000_0000;
        end
        else
        begin
            if (resp_evt)
            begin
                // only handshake flags, upper bits zero
                rsp_ctrl_reg <= {5'h00, cmd_reg[0][2:0] & cwr_pkg::CTRL_FLAG_MASK};
                rsp_cmd_reg <= cmd_code;
                rsp_status_reg <= resp_status_next;
                rsp_count_reg <= rsp_count_reg + 8'h01;
            end
            if (state_reg == cwr_pkg::ST_WAIT_HEAD && head_done && is_frd)
                code_reg <= head_rdata;
            // Set wins over clear
            irq_st_reg <= (irq_st_reg & ~(clr_acc ? avs_writedata : 32'h0000_0000))
                | {29'h0, evt};
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_fail_done;
        state_reg == cwr_pkg::ST_WAIT_HEAD && head_done && !head_ok && is_cfg && !cmd_start;
    endsequence
    sequence s_reissue;
        state_reg == cwr_pkg::ST_START ##1 state_reg == cwr_pkg::ST_ISSUE ##1 head_req;
    endsequence

    echo_code_a: assert property (resp_evt |=> rsp_cmd_reg == $past(cmd_code))
        else $error("response code not echoed");
    retry_fail_a: assert property (s_fail_done |=> state_reg == cwr_pkg::ST_WAIT_LEAVE)
        else $error("failed write did not stay alive");
    report_each_a: assert property (state_reg == cwr_pkg::ST_WAIT_HEAD && head_done
        && !cmd_start |=> rsp_count_reg == $past(rsp_count_reg) + 8'h01)
        else $error("attempt not reported");
    restart_new_a: assert property (state_reg == cwr_pkg::ST_WAIT_LEAVE && tag_new
        && !cmd_start ##0 (tag_present [*2]) |-> ##[0:1] s_reissue)
        else $error("new tag did not restart sequence");
    pw_gate_a: assert property (state_reg == cwr_pkg::ST_START && is_cfg && !pw_mode
        && !cmd_start |=> rsp_status_reg == cwr_pkg::STAT_NO_PW && !head_req [*2])
        else $error("configuration write without password mode");
    absent_only_a: assert property (resp_evt && resp_status_next == cwr_pkg::STAT_NO_TAG
        |-> !tag_present)
        else $error("05h with tag present");
    no_gap_a: assert property (state_reg == cwr_pkg::ST_WAIT_LEAVE && tag_new
        |-> !resp_evt)
        else $error("05h between successive tags");
    no_verify_a: assert property (head_req && head_op == cwr_pkg::OP_FIX_WR
        |-> !head_verify)
        else $error("fixed-code write with verify");
    emul_len_a: assert property (issue_go && is_fwr && tag_type == cwr_pkg::TT_B_PROG
        |=> head_req && head_len == cwr_pkg::LEN_EMUL_AREA)
        else $error("emulation area length wrong");
    native_read_a: assert property (issue_go && is_frd
        |=> head_op == ($past(tag_type) == cwr_pkg::TT_B_PROG ?
        cwr_pkg::OP_RD_NATIVE : cwr_pkg::OP_RD_EMUL))
        else $error("fixed-code read source wrong");
endmodule // cwr_config_word_retry_write

/* File: pkg/cwr_pkg.sv */
// Purpose: Constants for the retrying configuration-word write interpreter
// Assumes: Avalon-MM byte addresses, 32-bit data
// Notes: Fixed-code command codes and error statuses are plain defaults
package cwr_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [5:0] OFS_CMD0 = 6'h00;
    localparam logic [5:0] OFS_CMD1 = 6'h04;
    localparam logic [5:0] OFS_CMD2 = 6'h08;
    localparam logic [5:0] OFS_RSP0 = 6'h10;
    localparam logic [5:0] OFS_RSP1 = 6'h14;
    localparam logic [5:0] OFS_CTRL = 6'h18;
    localparam logic [5:0] OFS_STATE = 6'h1C;
    localparam logic [5:0] OFS_IRQ_ST = 6'h20;
    localparam logic [5:0] OFS_IRQ_CLR = 6'h24;
    localparam logic [5:0] OFS_IRQ_EN = 6'h28;
    localparam logic [5:0] OFS_CODE = 6'h2C;
    // ****************************************
    // Command codes and statuses
    // ****************************************
    localparam logic [7:0] CMD_CFG_RETRY = 8'h66;
    // Arbitrary fixed-code command values
    localparam logic [7:0] CMD_FIX_WR_S = 8'h41;
    localparam logic [7:0] CMD_FIX_WR_E = 8'h42;
    localparam logic [7:0] CMD_FIX_RD_S = 8'h43;
    localparam logic [7:0] CMD_FIX_RD_E = 8'h44;
    localparam logic [7:0] STAT_OK = 8'h00;
    localparam logic [7:0] STAT_NO_TAG = 8'h05;
    localparam logic [7:0] STAT_NO_PW = 8'h0E;
    localparam logic [7:0] STAT_BAD_CMD = 8'h0F;
    // ****************************************
    // Fields, head operations, reset values
    // ****************************************
    localparam int CTRL_PW_BIT = 0;
    localparam int CTRL_VERIFY_BIT = 1;
    localparam int CTRL_TT_LSB = 8;
    localparam logic [1:0] TT_A = 2'h1;
    localparam logic [1:0] TT_B_PROG = 2'h2;
    localparam logic [1:0] TT_B_READ = 2'h3;
    localparam logic [1:0] OP_CFG_WR = 2'h0;
    localparam logic [1:0] OP_FIX_WR = 2'h1;
    localparam logic [1:0] OP_RD_EMUL = 2'h2;
    localparam logic [1:0] OP_RD_NATIVE = 2'h3;
    localparam logic [3:0] LEN_WORD = 4'h4;
    localparam logic [3:0] LEN_EMUL_AREA = 4'h8;
    localparam logic [2:0] CTRL_FLAG_MASK = 3'h7;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int IRQ_RESP = 0;
    localparam int IRQ_WR_OK = 1;
    localparam int IRQ_NO_TAG = 2;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_START = 3'b001,
        ST_ISSUE = 3'b010,
        ST_WAIT_HEAD = 3'b011,
        ST_WAIT_LEAVE = 3'b100,
        ST_WAIT_TAG = 3'b101
    } cwr_state_t;
endpackage

/* File: tb/cwr_head_model.sv */
// Purpose: Read/write head model answering head requests
// Assumes: head_req is a one-cycle pulse
// Notes: Fails the first fail_n attempts; answer lines scramble when idle
`timescale 1ns/1ps
module cwr_head_model (
    input wire logic ref_clk,
    input wire logic head_req,
    input wire logic [1:0] head_op,
    input wire logic [7:0] head_addr,
    input wire logic [31:0] head_data,
    input wire logic [3:0] head_len,
    input wire logic head_verify,
    input wire logic [7:0] fail_n,
    output logic head_done,
    output logic head_ok,
    output logic [7:0] head_status,
    output logic [31:0] head_rdata
);
    // Arbitrary code value and failure status
    parameter logic [31:0] CODE_VAL = 32'h3C5A_96E1;
    parameter logic [7:0] FAIL_ST = 8'h0A;
    logic [1:0] cap_op = 2'h0;
    logic [7:0] cap_addr = 8'h00;
    logic [31:0] cap_data = 32'h0;
    logic [3:0] cap_len = 4'h0;
    logic cap_ver = 1'b0;
    logic [7:0] req_cnt = 8'h00;
    logic [2:0] dly = 3'h0;
    initial
    begin
        head_done = 1'b0;
        head_ok = 1'b0;
        head_status = 8'h00;
        head_rdata = 32'h0;
    end
    always @(posedge ref_clk)
    begin
        head_done <= 1'b0;
        head_ok <= ~head_ok;
        head_status <= ~head_status;
        head_rdata <= ~head_rdata;
        if (head_req === 1'b1)
        begin
            cap_op <= head_op;
            cap_addr <= head_addr;
            cap_data <= head_data;
            cap_len <= head_len;
            cap_ver <= head_verify;
            req_cnt <= req_cnt + 8'h01;
            dly <= 3'h3;
        end
        else if (dly != 3'h0)
        begin
            dly <= dly - 3'h1;
            if (dly == 3'h1)
            begin
                head_done <= 1'b1;
                head_ok <= (req_cnt > fail_n);
                head_status <= FAIL_ST;
                head_rdata <= CODE_VAL;
            end
        end
    end
endmodule // cwr_head_model

/* File: tb/test_cwr_config_word_retry_write.sv */
// Purpose: Self-checking bench for the retrying config-word write
// Assumes: One wait state per bus access
// Notes: Head model fails the first two attempts
`timescale 1ns/1ps
module test_cwr_config_word_retry_write;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, irq, head_req, head_verify, head_done, head_ok;
    logic [1:0] head_op;
    logic [7:0] head_addr, head_status;
    logic [31:0] head_data, head_rdata;
    logic [3:0] head_len;
    logic tag_present = 1'b0;
    logic tag_new = 1'b0;
    int mismatches = 0;
    int n_tests = 0;
    logic [7:0] f_code [4] = '{cwr_pkg::CMD_FIX_WR_S, cwr_pkg::CMD_FIX_WR_E,
        cwr_pkg::CMD_FIX_RD_S, cwr_pkg::CMD_FIX_RD_E};
    logic [1:0] f_tt [4] = '{cwr_pkg::TT_B_PROG, cwr_pkg::TT_A,
        cwr_pkg::TT_B_READ, cwr_pkg::TT_B_PROG};
    logic [1:0] f_op [4] = '{cwr_pkg::OP_FIX_WR, cwr_pkg::OP_FIX_WR,
        cwr_pkg::OP_RD_EMUL, cwr_pkg::OP_RD_NATIVE};
    logic [3:0] f_len [2] = '{cwr_pkg::LEN_EMUL_AREA, cwr_pkg::LEN_WORD};
    cwr_config_word_retry_write dut_u (.ref_clk(ref_clk), .resetn(resetn),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
        .head_req(head_req), .head_op(head_op), .head_addr(head_addr),
        .head_data(head_data), .head_len(head_len), .head_verify(head_verify),
        .head_done(head_done), .head_ok(head_ok), .head_status(head_status),
        .head_rdata(head_rdata), .tag_present(tag_present), .tag_new(tag_new));
    cwr_head_model head_u (.ref_clk(ref_clk), .head_req(head_req), .head_op(head_op),
        .head_addr(head_addr), .head_data(head_data), .head_len(head_len),
        .head_verify(head_verify), .fail_n(8'h02), .head_done(head_done),
        .head_ok(head_ok), .head_status(head_status), .head_rdata(head_rdata));
    initial
    begin
        forever #20 ref_clk = ~ref_clk;
    end
    // ****************************************
    // Bus and check tasks
    // ****************************************
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= ~w;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 20);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (avs_waitrequest !== 1'b0)
        begin
            mismatches++;
            stop_test();
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
        @(posedge ref_clk);
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    task automatic run(input logic [7:0] code, input logic [31:0] ctl);
        wr(cwr_pkg::OFS_CTRL, ctl);
        wr(cwr_pkg::OFS_CMD2, 32'h4433_2211);
        wr(cwr_pkg::OFS_CMD1, 32'h0000_0200);
        wr(cwr_pkg::OFS_CMD0, {8'h00, code, 16'h0005});
    endtask
    task automatic wait_rsp(input logic [7:0] c, input logic [7:0] s);
        logic [31:0] q;
        int n;
        n = 0;
        do
        begin
            bus(1'b0, cwr_pkg::OFS_RSP1, 32'h0, q);
            n++;
        end
        while (q[15:8] !== c && n < 60);
        chk(q, {16'h0000, c, s});
        if (q[15:8] !== c)
            stop_test();
    endtask
    task automatic new_tag();
        @(posedge ref_clk);
        tag_present <= 1'b1;
        tag_new <= 1'b1;
        @(posedge ref_clk);
        tag_new <= 1'b0;
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd_chk(cwr_pkg::OFS_CTRL, cwr_pkg::CTRL_RESET);
        rd_chk(6'h3C, 32'h0);
        wr(cwr_pkg::OFS_IRQ_EN, 32'h0000_0007);
        $display("Test registers finished");
        run(cwr_pkg::CMD_CFG_RETRY, 32'h0000_0103);
        wait_rsp(8'h01, cwr_pkg::STAT_NO_TAG);
        rd_chk(cwr_pkg::OFS_IRQ_ST, 32'h0000_0005);
        chk({31'h0, irq}, 32'h1);
        wr(cwr_pkg::OFS_IRQ_CLR, 32'h0000_0007);
        chk({31'h0, irq}, 32'h0);
        new_tag();
        wait_rsp(8'h02, head_u.FAIL_ST);
        chk({30'h0, head_u.cap_op}, {30'h0, cwr_pkg::OP_CFG_WR});
        chk({24'h0, head_u.cap_addr}, 32'h0000_0002);
        chk(head_u.cap_data, 32'h1122_3344);
        chk({31'h0, head_u.cap_ver}, 32'h1);
        new_tag();
        wait_rsp(8'h03, head_u.FAIL_ST);
        @(posedge ref_clk);
        tag_present <= 1'b0;
        wait_rsp(8'h04, cwr_pkg::STAT_NO_TAG);
        new_tag();
        wait_rsp(8'h05, cwr_pkg::STAT_OK);
        chk({24'h0, head_u.req_cnt}, 32'h0000_0003);
        rd_chk(cwr_pkg::OFS_RSP0, 32'h0066_0005);
        rd_chk(cwr_pkg::OFS_IRQ_ST, 32'h0000_0007);
        wr(cwr_pkg::OFS_IRQ_EN, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr(cwr_pkg::OFS_IRQ_EN, 32'h0000_0002);
        wr(cwr_pkg::OFS_IRQ_CLR, 32'h0000_0002);
        rd_chk(cwr_pkg::OFS_IRQ_ST, 32'h0000_0005);
        chk({31'h0, irq}, 32'h0);
        $display("Test retry finished");
        run(cwr_pkg::CMD_CFG_RETRY, 32'h0000_0102);
        wait_rsp(8'h06, cwr_pkg::STAT_NO_PW);
        chk({24'h0, head_u.req_cnt}, 32'h0000_0003);
        $display("Test password finished");
        for (int i = 0; i < 4; i++)
        begin
            run(f_code[i], {22'h0, f_tt[i], 8'h03});
            wait_rsp(8'h07 + 8'(i), cwr_pkg::STAT_OK);
            chk({30'h0, head_u.cap_op}, {30'h0, f_op[i]});
            if (i < 2)
            begin
                chk({28'h0, head_u.cap_len}, {28'h0, f_len[i]});
                chk({31'h0, head_u.cap_ver}, 32'h0);
            end
            else
                rd_chk(cwr_pkg::OFS_CODE, head_u.CODE_VAL);
        end
        $display("Test fixed code finished");
        run(8'h77, 32'h0000_0103);
        wait_rsp(8'h0B, cwr_pkg::STAT_BAD_CMD);
        $display("Test bad command finished");
        stop_test();
    end
endmodule // test_cwr_config_word_retry_write
